// file: design/input_pin_route.sv
// Picks one port pin for a peripheral input from a selector code.
`timescale 1ns/10ps
module input_pin_route
   import pps_pkg::*;
(
   // Selector code
   input wire logic [SEL_W-1:0] code,
   // Port pins
   input wire logic [PORT_W-1:0] pin_in_a,
   input wire logic [PORT_W-1:0] pin_in_b,
   input wire logic [PORT_W-1:0] pin_in_c,
   // Routed level
   output logic selected
);

   logic [2:0] bit_sel;

   always_comb begin
      bit_sel = code[2:0];
      unique case (code[4:3])
         PORT_A: selected = pin_in_a[bit_sel];
         PORT_B: selected = pin_in_b[bit_sel];
         PORT_C: selected = pin_in_c[bit_sel];
         PORT_RSVD: selected = 1'b0;
      endcase
   end

endmodule

// file: design/peripheral_pin_select_lock.sv
// Pin routing selectors with lock, reached over an AHB-Lite slave port.
`timescale 1ns/10ps
module peripheral_pin_select_lock
   import pps_pkg::*;
#(
   parameter int OUT_PINS = NUM_OUT_PINS,
   parameter bit LARGE_PACKAGE = 1'b1
) (
   // Clock and resets
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic warm_reset,
   // Configuration
   input wire logic one_shot_lock_option,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [DATA_W-1:0] hrdata,
   output logic hresp,
   // Port pins and peripheral signals
   input wire logic [PORT_W-1:0] pin_in_a,
   input wire logic [PORT_W-1:0] pin_in_b,
   input wire logic [PORT_W-1:0] pin_in_c,
   input wire logic [OUT_PINS-1:0] latch_out,
   input wire logic [31:0] periph_out_signals,
   // Routed outputs
   output logic [OUT_PINS-1:0] pin_out,
   output logic [NUM_IN_SEL-1:0] periph_in,
   output logic routing_locked_flag
);

   // ****************************************
   // Elaboration check
   // ****************************************
   generate
      if (OUT_PINS < 1 || OUT_PINS > MAX_SLOTS) begin : g_bad_pins
         $error("OUT_PINS must lie between 1 and 64");
      end
      if (SEL_W != 5 || PORT_W != 8 || DATA_W < 8) begin : g_bad_widths
         $error("Selector decode needs five-bit codes, eight-pin ports, byte-wide data");
      end
      if (NUM_IN_SEL < 1 || NUM_IN_SEL > MAX_SLOTS) begin : g_bad_inputs
         $error("Input selector count must lie between 1 and 64");
      end
   endgenerate

   // ****************************************
   // Bus phase tracking
   // ****************************************
   logic accept;
   logic wr_pend;
   logic rd_stage;
   logic [31:0] addr_q;
   logic next_wr_pend;
   logic next_rd_stage;
   logic [31:0] next_addr_q;
   logic next_hreadyout;
   logic next_hresp;
   logic [2:0] hsize_q;
   logic [2:0] next_hsize_q;

   assign accept = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;

   always_comb begin
      next_wr_pend = accept & hwrite;
      next_rd_stage = accept & ~hwrite;
      next_addr_q = addr_q;
      next_hsize_q = hsize_q;
      if (accept) begin
         next_addr_q = haddr;
         next_hsize_q = hsize;
      end
      next_hreadyout = ~(accept & ~hwrite);
      next_hresp = 1'b0;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         rd_stage <= 1'b0;
         addr_q <= 32'h0000_0000;
         hsize_q <= 3'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= next_wr_pend;
         rd_stage <= next_rd_stage;
         addr_q <= next_addr_q;
         hsize_q <= next_hsize_q;
         hreadyout <= next_hreadyout;
         hresp <= next_hresp;
      end
   end

   // ****************************************
   // Address decode
   // ****************************************
   logic aligned;
   logic lock_hit;
   logic out_page_hit;
   logic in_page_hit;
   logic [5:0] slot;

   always_comb begin
      aligned = (addr_q[1:0] == 2'h0);
      slot = addr_q[7:2];
      lock_hit = aligned && (addr_q == LOCK_OFFSET);
      out_page_hit = aligned && (addr_q[31:8] == OUT_PAGE);
      in_page_hit = aligned && (addr_q[31:8] == IN_PAGE);
   end

   // ****************************************
   // Lock flag and unlock sequence
   // ****************************************
   key_state_type key_state;
   key_state_type next_key_state;
   logic clear_used;
   logic next_clear_used;
   logic next_locked;
   logic [7:0] wbyte;

   always_comb begin
      wbyte = hwdata[7:0];
      next_key_state = key_state;
      next_locked = routing_locked_flag;
      next_clear_used = clear_used;
      if (warm_reset) begin
         next_key_state = KEY_IDLE;
         next_locked = LOCK_RESET;
         next_clear_used = 1'b0;
      end else if (wr_pend && lock_hit) begin
         unique case (key_state)
            KEY_IDLE: begin
               if (wbyte == KEY_FIRST) begin
                  next_key_state = KEY_FIRST_SEEN;
               end
            end
            KEY_FIRST_SEEN: begin
               if (wbyte == KEY_SECOND) begin
                  next_key_state = KEY_ARMED;
               end else begin
                  next_key_state = KEY_IDLE;
               end
            end
            KEY_ARMED: begin
               next_key_state = KEY_IDLE;
               if (hwdata[LOCK_BIT]) begin
                  next_locked = 1'b1;
               end else if (!(one_shot_lock_option && clear_used)) begin
                  next_locked = 1'b0;
                  if (routing_locked_flag) begin
                     next_clear_used = 1'b1;
                  end
               end
            end
            default: next_key_state = KEY_IDLE;
         endcase
      end else if (wr_pend) begin
         next_key_state = KEY_IDLE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         key_state <= KEY_IDLE;
         routing_locked_flag <= LOCK_RESET;
         clear_used <= 1'b0;
      end else begin
         key_state <= next_key_state;
         routing_locked_flag <= next_locked;
         clear_used <= next_clear_used;
      end
   end

   // ****************************************
   // Selector write enables
   // ****************************************
   logic sel_write_ok;

   // Warm reset leaves selectors alone but still blocks a write in its cycle.
   assign sel_write_ok = wr_pend && !routing_locked_flag && !warm_reset;

   // ****************************************
   // Output source selectors
   // ****************************************
   logic [SEL_W-1:0] out_code [OUT_PINS];
   logic [OUT_PINS-1:0] next_pin_out;

   generate
      for (genvar i = 0; i < OUT_PINS; i++) begin : g_out
         logic out_we;
         assign out_we = sel_write_ok && out_page_hit && (slot == 6'(i));
         routing_select_reg #(
            .RESET_CODE(OUT_RESET)
         ) u_out_sel (
            .hclk(hclk),
            .hresetn(hresetn),
            .write_en(out_we),
            .write_data(hwdata[SEL_W-1:0]),
            .code(out_code[i])
         );
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < OUT_PINS; i++) begin
         if (out_code[i] == OUT_CODE_LATCH) begin
            next_pin_out[i] = latch_out[i];
         end else if (out_code[i] == OUT_CODE_RSVD || out_code[i][4:1] == OUT_CODE_RSVD_TOP) begin
            next_pin_out[i] = 1'b0;
         end else begin
            next_pin_out[i] = periph_out_signals[out_code[i]];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= '0;
      end else begin
         pin_out <= next_pin_out;
      end
   end

   // ****************************************
   // Input pin selectors
   // ****************************************
   localparam logic [SEL_W-1:0] SS_RESET = LARGE_PACKAGE ? SS_RESET_LARGE : SS_RESET_SMALL;
   logic [SEL_W-1:0] in_code [NUM_IN_SEL];
   logic [NUM_IN_SEL-1:0] routed;

   generate
      for (genvar j = 0; j < NUM_IN_SEL; j++) begin : g_in
         localparam logic [SEL_W-1:0] RST =
            (j == IDX_SERIAL_SS) ? SS_RESET : IN_SEL_RESET[j];
         logic in_we;
         assign in_we = sel_write_ok && in_page_hit && (slot == 6'(j));
         routing_select_reg #(
            .RESET_CODE(RST)
         ) u_in_sel (
            .hclk(hclk),
            .hresetn(hresetn),
            .write_en(in_we),
            .write_data(hwdata[SEL_W-1:0]),
            .code(in_code[j])
         );
         input_pin_route u_route (
            .code(in_code[j]),
            .pin_in_a(pin_in_a),
            .pin_in_b(pin_in_b),
            .pin_in_c(pin_in_c),
            .selected(routed[j])
         );
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         periph_in <= '0;
      end else begin
         periph_in <= routed;
      end
   end

   // ****************************************
   // Read selection
   // ****************************************
   logic out_slot_hit;
   logic in_slot_hit;
   logic [SEL_W-1:0] out_read;
   logic [SEL_W-1:0] in_read;

   always_comb begin
      out_slot_hit = 1'b0;
      out_read = '0;
      for (int i = 0; i < OUT_PINS; i++) begin
         if (slot == 6'(i)) begin
            out_slot_hit = 1'b1;
            out_read = out_code[i];
         end
      end
   end

   always_comb begin
      in_slot_hit = 1'b0;
      in_read = '0;
      for (int j = 0; j < NUM_IN_SEL; j++) begin
         if (slot == 6'(j)) begin
            in_slot_hit = 1'b1;
            in_read = in_code[j];
         end
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   logic [DATA_W-1:0] next_hrdata;

   always_comb begin
      next_hrdata = hrdata;
      if (rd_stage) begin
         next_hrdata = '0;
         if (lock_hit) begin
            next_hrdata = DATA_W'(routing_locked_flag);
         end else if (out_page_hit && out_slot_hit) begin
            next_hrdata = DATA_W'(out_read);
         end else if (in_page_hit && in_slot_hit) begin
            next_hrdata = DATA_W'(in_read);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else begin
         hrdata <= next_hrdata;
      end
   end

endmodule

// file: design/pps_pkg.sv
// Constants, register map and state codes of the pin routing block.
package pps_pkg;

   // ****************************************
   // Widths and counts
   // ****************************************
   localparam int SEL_W = 5;
   localparam int DATA_W = 32;
   localparam int PORT_W = 8;
   localparam int NUM_OUT_PINS = 24;
   localparam int NUM_IN_SEL = 13;
   localparam int MAX_SLOTS = 64;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [31:0] LOCK_OFFSET = 32'h0000_0000;
   localparam logic [31:0] OUT_SEL_BASE = 32'h0000_0100;
   localparam logic [31:0] IN_SEL_BASE = 32'h0000_0200;
   localparam logic [23:0] OUT_PAGE = 24'h000001;
   localparam logic [23:0] IN_PAGE = 24'h000002;

   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int LOCK_BIT = 0;
   localparam logic LOCK_RESET = 1'b0;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;
   localparam logic [SEL_W-1:0] OUT_RESET = 5'h00;
   localparam logic [SEL_W-1:0] OUT_CODE_LATCH = 5'h00;
   localparam logic [SEL_W-1:0] OUT_CODE_RSVD = 5'h15;
   localparam logic [3:0] OUT_CODE_RSVD_TOP = 4'hF;
   localparam logic [1:0] PORT_A = 2'h0;
   localparam logic [1:0] PORT_B = 2'h1;
   localparam logic [1:0] PORT_C = 2'h2;
   localparam logic [1:0] PORT_RSVD = 2'h3;
   localparam int HTRANS_ACTIVE_BIT = 1;

   // ****************************************
   // Input selector indices and defaults
   // ****************************************
   localparam int IDX_SERIAL_SS = 7;
   localparam logic [SEL_W-1:0] SS_RESET_LARGE = 5'h16;
   localparam logic [SEL_W-1:0] SS_RESET_SMALL = 5'h13;
   // Order: change irq, timer0 clk, timer1 clk, timer1 gate, timer6 clk,
   // capture1, compgen1, serial slave select, modulator1 high, low, mod,
   // ramp1 set rising, ramp1 set falling.
   localparam logic [SEL_W-1:0] IN_SEL_RESET [NUM_IN_SEL] = '{
      5'h02, 5'h02, 5'h05, 5'h04, 5'h03, 5'h15, 5'h02,
      5'h16, 5'h03, 5'h04, 5'h05, 5'h14, 5'h15};

   // ****************************************
   // Unlock sequence states
   // ****************************************
   typedef enum logic [2:0] {
      KEY_IDLE = 3'b001,
      KEY_FIRST_SEEN = 3'b010,
      KEY_ARMED = 3'b100
   } key_state_type;

endpackage

// file: design/routing_select_reg.sv
// One five-bit routing selector held through all but power-on reset.
`timescale 1ns/10ps
module routing_select_reg
   import pps_pkg::*;
#(
   parameter logic [SEL_W-1:0] RESET_CODE = 5'h00
) (
   // Clock and power-on reset
   input wire logic hclk,
   input wire logic hresetn,
   // Gated write
   input wire logic write_en,
   input wire logic [SEL_W-1:0] write_data,
   // Held code
   output logic [SEL_W-1:0] code
);

   logic [SEL_W-1:0] next_code;

   always_comb begin
      next_code = code;
      if (write_en) begin
         next_code = write_data;
      end
   end

   // Only the power-on reset loads RESET_CODE into the code; warm resets do not reach here.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         code <= RESET_CODE;
      end else begin
         code <= next_code;
      end
   end

endmodule

// file: verif/peripheral_pin_select_lock_test.sv
// Self-checking bench with a register and routing model of the pin routing block.
`timescale 1ns/10ps
module peripheral_pin_select_lock_test
   import pps_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic warm_reset = 1'b0;
   logic one_shot_lock_option = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic [7:0] pin_in_a = 8'h0;
   logic [7:0] pin_in_b = 8'h0;
   logic [7:0] pin_in_c = 8'h0;
   logic [23:0] latch_out = 24'h0;
   logic [31:0] periph_out_signals = 32'h0;
   logic [23:0] pin_out;
   logic [12:0] periph_in;
   logic routing_locked_flag;
   logic [31:0] rd;
   int error_cnt = 0;
   int num_checks = 0;
   int out_m [24];
   int in_m [13];
   int in_def [13] = '{5'h02, 5'h02, 5'h05, 5'h04, 5'h03, 5'h15, 5'h02, 5'h16, 5'h03,
      5'h04, 5'h05, 5'h14, 5'h15};
   int lock_m;
   int ks;
   int used;
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   peripheral_pin_select_lock u_peripheral_pin_select_lock (.hclk(hclk), .hresetn(hresetn),
      .warm_reset(warm_reset), .one_shot_lock_option(one_shot_lock_option), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .pin_in_a(pin_in_a), .pin_in_b(pin_in_b), .pin_in_c(pin_in_c), .latch_out(latch_out),
      .periph_out_signals(periph_out_signals), .pin_out(pin_out), .periph_in(periph_in),
      .routing_locked_flag(routing_locked_flag));
   // ********
   // Tasks
   // ********
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   function automatic int idx(input logic [31:0] a, input logic [31:0] b, input int n);
      if (a[1:0] == 2'h0 && a >= b && a < b + 4 * n) begin
         return int'((a - b) >> 2);
      end
      return -1;
   endfunction
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hreadyout) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      int i;
      int j;
      i = idx(a, OUT_SEL_BASE, 24);
      j = idx(a, IN_SEL_BASE, 13);
      xfer(a, 1'b1, d);
      if (a == LOCK_OFFSET && ks == 2) begin
         if (!(lock_m == 1 && !d[0] && used == 1 && one_shot_lock_option)) begin
            used = (lock_m == 1 && !d[0]) ? 1 : used;
            lock_m = d[0];
         end
         ks = 0;
      end else if (a == LOCK_OFFSET) begin
         ks = (ks == 1) ? ((d[7:0] == 8'hAA) ? 2 : 0) : ((d[7:0] == 8'h55) ? 1 : 0);
      end else begin
         ks = 0;
         if (lock_m == 0 && i >= 0) out_m[i] = d[4:0];
         if (lock_m == 0 && j >= 0) in_m[j] = d[4:0];
      end
   endtask
   task automatic rd_chk(input logic [31:0] a);
      int i;
      int j;
      int e;
      i = idx(a, OUT_SEL_BASE, 24);
      j = idx(a, IN_SEL_BASE, 13);
      e = (a == LOCK_OFFSET) ? lock_m : (i >= 0) ? out_m[i] : (j >= 0) ? in_m[j] : 0;
      xfer(a, 1'b0, 32'h0);
      chk(rd, e);
   endtask
   task automatic rd_all();
      @(negedge hclk);
      chk(routing_locked_flag, lock_m);
      rd_chk(LOCK_OFFSET);
      for (int i = 0; i < 24; i++) rd_chk(OUT_SEL_BASE + 4 * i);
      for (int j = 0; j < 13; j++) rd_chk(IN_SEL_BASE + 4 * j);
      rd_chk(32'h0000_0160);
      rd_chk(32'h0000_0300);
   endtask
   task automatic route_chk();
      logic [23:0] ep;
      logic [12:0] ei;
      logic [23:0] pins;
      int c;
      @(posedge hclk);
      pin_in_a <= 8'($urandom);
      pin_in_b <= 8'($urandom);
      pin_in_c <= 8'($urandom);
      latch_out <= 24'($urandom);
      periph_out_signals <= $urandom;
      repeat (2) @(posedge hclk);
      @(negedge hclk);
      pins = {pin_in_c, pin_in_b, pin_in_a};
      for (int i = 0; i < 24; i++) begin
         c = out_m[i];
         ep[i] = (c == 0) ? latch_out[i] : (c == 5'h15 || c >= 5'h1E) ? 1'b0 :
            periph_out_signals[c];
      end
      for (int j = 0; j < 13; j++) begin
         c = in_m[j];
         ei[j] = (c < 24) ? pins[c] : 1'b0;
      end
      chk(pin_out, ep);
      chk(periph_in, ei);
   endtask
   task automatic model_reset();
      foreach (out_m[i]) out_m[i] = 0;
      foreach (in_m[j]) in_m[j] = in_def[j];
      lock_m = 0;
      ks = 0;
      used = 0;
   endtask
   task automatic lock_seq(input logic b);
      wr(LOCK_OFFSET, 32'h55);
      wr(LOCK_OFFSET, 32'hAA);
      wr(LOCK_OFFSET, {31'h0, b});
   endtask
   task automatic warm();
      @(posedge hclk);
      warm_reset <= 1'b1;
      @(posedge hclk);
      warm_reset <= 1'b0;
      model_reset_lock();
   endtask
   task automatic model_reset_lock();
      lock_m = 0;
      ks = 0;
      used = 0;
   endtask
   // ********
   // Sequence
   // ********
   initial begin
      void'($urandom(32'h2d96));
      model_reset();
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rd_all();
      route_chk();
      for (int k = 0; k < 32; k++) begin
         wr(OUT_SEL_BASE + 4 * (k % 24), {27'($urandom), 5'(k)});
         wr(IN_SEL_BASE + 4 * (k % 13), {27'($urandom), 5'(k)});
         route_chk();
      end
      rd_all();
      lock_seq(1'b1);
      for (int k = 0; k < 6; k++) begin
         wr(OUT_SEL_BASE + 4 * k, $urandom);
         wr(IN_SEL_BASE + 4 * k, $urandom);
      end
      wr(LOCK_OFFSET, 32'hFF);
      rd_all();
      route_chk();
      lock_seq(1'b0);
      wr(LOCK_OFFSET, 32'h55);
      wr(OUT_SEL_BASE, 32'h3);
      wr(LOCK_OFFSET, 32'hAA);
      wr(LOCK_OFFSET, 32'h1);
      wr(LOCK_OFFSET, 32'h55);
      wr(LOCK_OFFSET, 32'h55);
      wr(LOCK_OFFSET, 32'hAA);
      wr(LOCK_OFFSET, 32'h1);
      rd_all();
      lock_seq(1'b1);
      warm();
      rd_all();
      @(posedge hclk);
      one_shot_lock_option <= 1'b1;
      warm();
      lock_seq(1'b1);
      lock_seq(1'b0);
      lock_seq(1'b1);
      lock_seq(1'b0);
      rd_all();
      warm();
      rd_all();
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      model_reset();
      rd_all();
      wrap_up();
   end
   initial begin
      #200000;
      error_cnt++;
      wrap_up();
   end
endmodule

// file: verif/pps_props.sv
// Bus timing and lock flag assertions for the pin routing block.
`timescale 1ns/10ps
module pps_props (
   // Clock and resets
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic warm_reset,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // Lock
   input wire logic routing_locked_flag
);
   logic take;
   logic wr_dp;
   logic next_wr_dp;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   assign take = hsel && htrans[1] && hready;
   always_comb begin
      next_wr_dp = take && hwrite;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_dp <= 1'b0;
      end else begin
         wr_dp <= next_wr_dp;
      end
   end
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_rd_wait;
      take && !hwrite |=> !hreadyout ##1 hreadyout;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
   property p_wr_fast;
      take && hwrite |=> hreadyout;
   endproperty
   a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
   property p_rd_top;
      $rose(hreadyout) |-> hrdata[31:5] == 27'h0;
   endproperty
   a_rd_top: assert property (p_rd_top) else $error("upper read bits set");
   property p_hold;
      !$rose(hreadyout) |-> $stable(hrdata);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_fall;
      $fell(hreadyout) |-> $past(take && !hwrite);
   endproperty
   a_fall: assert property (p_fall) else $error("stall without read");
   property p_warm;
      warm_reset |=> !routing_locked_flag;
   endproperty
   a_warm: assert property (p_warm) else $error("flag kept over reset");
   property p_flag;
      $changed(routing_locked_flag) |-> $past(warm_reset) || $past(wr_dp);
   endproperty
   a_flag: assert property (p_flag) else $error("flag moved alone");
endmodule

bind peripheral_pin_select_lock pps_props u_pps_props (.hclk, .hresetn, .warm_reset,
   .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata, .hresp, .routing_locked_flag);
